// File: design/upc_map.vh
`ifndef UPC_MAP_VH
`define UPC_MAP_VH
// Opcodes received on the command endpoint.
`define UPC_OP_RD_VER     8'h00
`define UPC_OP_RD_DM      8'h20
`define UPC_OP_WR_DM      8'h22
`define UPC_OP_RD_IE      8'h30
`define UPC_OP_WR_IE      8'h32
`define UPC_OP_RD_GS      8'h34
`define UPC_OP_WR_GS      8'h36
`define UPC_OP_RD_IC      8'h38
`define UPC_OP_WR_IC      8'h3A
`define UPC_OP_SET_DM     8'h40
// Response code is the opcode plus this step.
`define UPC_RSP_STEP      8'h01
// Response lengths in bytes, checksum included.
`define UPC_LEN_VER       8'h05
`define UPC_LEN_ONE       8'h05
`define UPC_LEN_TWO       8'h06
`define UPC_LEN_THREE     8'h07
`define UPC_LEN_ERR       8'h04
// Error codes.
`define UPC_ERR_NONE      8'h00
`define UPC_ERR_OPCODE    8'h01
`define UPC_ERR_PORT      8'h02
`define UPC_ERR_MODE      8'h03
// Valid port numbers.
`define UPC_PORT_A        8'h00
`define UPC_PORT_B        8'h02
`define UPC_PORT_C        8'h03
`define UPC_PORT_D        8'h04
// Drive modes.
`define UPC_DM_RESET      3'h7
`define UPC_DM_MAX        8'h07
`define UPC_DM_INPUT      3'h2
// Byte positions inside a packet.
`define UPC_POS_OPCODE    3'h0
`define UPC_POS_PORT      3'h1
`define UPC_POS_DATA0     3'h2
`define UPC_POS_DATA1     3'h3
`define UPC_POS_DATA2     3'h4
`define UPC_CMD_BYTES     5
`endif

// File: design/upc_resp_tx.v
`timescale 1ns/1ps
`include "upc_map.vh"
// Streams a response of up to six bytes and appends the modulo-256 checksum.
module upc_resp_tx (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        load,
    input  wire [47:0] bytes_in,
    input  wire [2:0]  count_in,
    output reg  [7:0]  tdata_r,
    output reg         tvalid_r,
    output reg         tlast_r,
    input  wire        tready,
    output reg         busy_r
);
    reg [47:0] shift_r;
    reg [2:0]  left_r;
    reg [7:0]  sum_r;
    reg        sum_sent_r;

    // Byte zero sits in the low bits; the checksum follows the last data byte.
    always @(posedge sys_clk) begin
        if (rst) begin
            shift_r    <= 48'h0;
            left_r     <= 3'h0;
            sum_r      <= 8'h00;
            sum_sent_r <= 1'b0;
            tdata_r    <= 8'h00;
            tvalid_r   <= 1'b0;
            tlast_r    <= 1'b0;
            busy_r     <= 1'b0;
        end else if (load && !busy_r) begin
            shift_r    <= bytes_in;
            left_r     <= count_in;
            sum_r      <= 8'h00;
            sum_sent_r <= 1'b0;
            busy_r     <= 1'b1;
        end else if (busy_r && (!tvalid_r || tready)) begin
            if (tvalid_r && tlast_r) begin
                // The checksum byte has just been accepted.
                tvalid_r <= 1'b0;
                tlast_r  <= 1'b0;
                busy_r   <= 1'b0;
            end else if (left_r != 3'h0) begin
                tdata_r  <= shift_r[7:0];
                tvalid_r <= 1'b1;
                tlast_r  <= 1'b0;
                sum_r    <= sum_r + shift_r[7:0];
                shift_r  <= {8'h00, shift_r[47:8]};
                left_r   <= left_r - 3'h1;
            end else if (!sum_sent_r) begin
                tdata_r    <= sum_r;
                tvalid_r   <= 1'b1;
                tlast_r    <= 1'b1;
                sum_sent_r <= 1'b1;
            end else begin
                tvalid_r <= 1'b0;
            end
        end
    end
endmodule // upc_resp_tx

// File: design/upc_cmd_handler.v
`timescale 1ns/1ps
`include "upc_map.vh"
module upc_cmd_handler #(
    parameter [7:0] FW_VERSION = 8'h01 // Arbitrary version value.
) (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire [7:0]  ep2_tdata,
    input  wire        ep2_tvalid,
    input  wire        ep2_tlast,
    output reg         ep2_tready_r,
    output wire [7:0]  ep1_tdata,
    output wire        ep1_tvalid,
    output wire        ep1_tlast,
    input  wire        ep1_tready,
    output reg  [31:0] drive_plane_two_r,
    output reg  [31:0] drive_plane_one_r,
    output reg  [31:0] drive_plane_zero_r,
    output reg  [31:0] port_irq_enable_r,
    output reg  [31:0] port_global_select_r,
    output reg  [31:0] irq_control_plane_one_r,
    output reg  [31:0] irq_control_plane_zero_r,
    output reg  [31:0] port_is_input_r
);
    localparam [1:0] ST_RECV = 2'h0;
    localparam [1:0] ST_EXEC = 2'h1;
    localparam [1:0] ST_SEND = 2'h2;
    localparam [1:0] ST_WAIT = 2'h3;
    // Reset drive mode, split into its three plane bits below.
    localparam [2:0] DM_RST  = `UPC_DM_RESET;

    reg [1:0]  state_r;
    reg [7:0]  cmd_r [0:`UPC_CMD_BYTES-1];
    reg [2:0]  pos_r;
    reg [7:0]  err_r;
    reg [47:0] rsp_bytes_r;
    reg [2:0]  rsp_count_r;
    reg        tx_load_r;
    wire       tx_busy;
    integer    i;
    integer    j;

    // Maps a port number onto a lane 0..3, or 7 when the number is invalid.
    function [2:0] port_lane;
        input [7:0] num;
        begin
            case (num)
                `UPC_PORT_A: port_lane = 3'h0;
                `UPC_PORT_B: port_lane = 3'h1;
                `UPC_PORT_C: port_lane = 3'h2;
                `UPC_PORT_D: port_lane = 3'h3;
                default:     port_lane = 3'h7;
            endcase
        end
    endfunction

    // Reads one byte lane of a 32-bit plane bank.
    function [7:0] lane_byte;
        input [31:0] bank;
        input [1:0]  lane;
        begin
            lane_byte = bank[lane*8 +: 8];
        end
    endfunction

    wire [7:0] op       = cmd_r[`UPC_POS_OPCODE];
    wire [2:0] lane_raw = port_lane(cmd_r[`UPC_POS_PORT]);
    wire [1:0] lane     = lane_raw[1:0];
    wire       port_ok  = (lane_raw != 3'h7);
    wire [7:0] rsp_code = op + `UPC_RSP_STEP;
    wire [7:0] mode_p2  = {8{cmd_r[`UPC_POS_DATA0][2]}};
    wire [7:0] mode_p1  = {8{cmd_r[`UPC_POS_DATA0][1]}};
    wire [7:0] mode_p0  = {8{cmd_r[`UPC_POS_DATA0][0]}};

    // Error classification, evaluated from the captured command.
    reg [7:0] err_nxt;
    always @* begin
        err_nxt = `UPC_ERR_NONE;
        case (op)
            `UPC_OP_RD_VER: err_nxt = `UPC_ERR_NONE;
            `UPC_OP_RD_DM, `UPC_OP_WR_DM, `UPC_OP_RD_IE, `UPC_OP_WR_IE,
            `UPC_OP_RD_GS, `UPC_OP_WR_GS, `UPC_OP_RD_IC, `UPC_OP_WR_IC: begin
                if (!port_ok)
                    err_nxt = `UPC_ERR_PORT;
            end
            `UPC_OP_SET_DM: begin
                if (!port_ok)
                    err_nxt = `UPC_ERR_PORT;
                else if (cmd_r[`UPC_POS_DATA0] > `UPC_DM_MAX)
                    err_nxt = `UPC_ERR_MODE;
            end
            default: err_nxt = `UPC_ERR_OPCODE;
        endcase
    end

    // Command capture, register writes and response assembly.
    always @(posedge sys_clk) begin
        if (rst) begin
            state_r      <= ST_RECV;
            pos_r        <= 3'h0;
            err_r        <= `UPC_ERR_NONE;
            rsp_bytes_r  <= 48'h0;
            rsp_count_r  <= 3'h0;
            tx_load_r    <= 1'b0;
            ep2_tready_r <= 1'b0;
            for (i = 0; i < `UPC_CMD_BYTES; i = i + 1)
                cmd_r[i] <= 8'h00;
            drive_plane_two_r        <= {32{DM_RST[2]}};
            drive_plane_one_r        <= {32{DM_RST[1]}};
            drive_plane_zero_r       <= {32{DM_RST[0]}};
            port_irq_enable_r        <= 32'h0;
            port_global_select_r     <= 32'h0;
            irq_control_plane_one_r  <= 32'h0;
            irq_control_plane_zero_r <= 32'h0;
        end else begin
            tx_load_r <= 1'b0;
            case (state_r)
                ST_RECV: begin
                    ep2_tready_r <= 1'b1;
                    if (ep2_tvalid && ep2_tready_r) begin
                        if (pos_r < `UPC_CMD_BYTES)
                            cmd_r[pos_r] <= ep2_tdata;
                        if (pos_r != 3'h7)
                            pos_r <= pos_r + 3'h1;
                        if (ep2_tlast) begin
                            ep2_tready_r <= 1'b0;
                            state_r      <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    err_r   <= err_nxt;
                    pos_r   <= 3'h0;
                    state_r <= ST_SEND;
                    if (err_nxt == `UPC_ERR_NONE) begin
                        case (op)
                            `UPC_OP_WR_DM: begin
                                drive_plane_two_r[lane*8 +: 8]  <= cmd_r[`UPC_POS_DATA0];
                                drive_plane_one_r[lane*8 +: 8]  <= cmd_r[`UPC_POS_DATA1];
                                drive_plane_zero_r[lane*8 +: 8] <= cmd_r[`UPC_POS_DATA2];
                            end
                            `UPC_OP_WR_IE:
                                port_irq_enable_r[lane*8 +: 8] <= cmd_r[`UPC_POS_DATA0];
                            `UPC_OP_WR_GS:
                                port_global_select_r[lane*8 +: 8] <= cmd_r[`UPC_POS_DATA0];
                            `UPC_OP_WR_IC: begin
                                irq_control_plane_one_r[lane*8 +: 8]  <= cmd_r[`UPC_POS_DATA0];
                                irq_control_plane_zero_r[lane*8 +: 8] <= cmd_r[`UPC_POS_DATA1];
                            end
                            `UPC_OP_SET_DM: begin
                                drive_plane_two_r[lane*8 +: 8]  <= mode_p2;
                                drive_plane_one_r[lane*8 +: 8]  <= mode_p1;
                                drive_plane_zero_r[lane*8 +: 8] <= mode_p0;
                            end
                            default: ;
                        endcase
                    end
                end
                ST_SEND: begin
                    rsp_bytes_r[7:0]   <= rsp_code;
                    rsp_bytes_r[23:16] <= err_r;
                    rsp_bytes_r[47:24] <= 24'h0;
                    if (err_r != `UPC_ERR_NONE) begin
                        // Errors return only the header; checksum still follows.
                        rsp_bytes_r[15:8] <= `UPC_LEN_ERR;
                        rsp_count_r       <= 3'h3;
                    end else begin
                        case (op)
                            `UPC_OP_RD_VER: begin
                                rsp_bytes_r[15:8]  <= `UPC_LEN_VER;
                                rsp_bytes_r[31:24] <= FW_VERSION;
                                rsp_count_r        <= 3'h4;
                            end
                            `UPC_OP_RD_DM, `UPC_OP_WR_DM, `UPC_OP_SET_DM: begin
                                rsp_bytes_r[15:8]  <= `UPC_LEN_THREE;
                                rsp_bytes_r[31:24] <= lane_byte(drive_plane_two_r, lane);
                                rsp_bytes_r[39:32] <= lane_byte(drive_plane_one_r, lane);
                                rsp_bytes_r[47:40] <= lane_byte(drive_plane_zero_r, lane);
                                rsp_count_r        <= 3'h6;
                            end
                            `UPC_OP_RD_IE, `UPC_OP_WR_IE: begin
                                rsp_bytes_r[15:8]  <= `UPC_LEN_ONE;
                                rsp_bytes_r[31:24] <= lane_byte(port_irq_enable_r, lane);
                                rsp_count_r        <= 3'h4;
                            end
                            `UPC_OP_RD_GS, `UPC_OP_WR_GS: begin
                                rsp_bytes_r[15:8]  <= `UPC_LEN_ONE;
                                rsp_bytes_r[31:24] <= lane_byte(port_global_select_r, lane);
                                rsp_count_r        <= 3'h4;
                            end
                            default: begin
                                rsp_bytes_r[15:8]  <= `UPC_LEN_TWO;
                                rsp_bytes_r[31:24] <= lane_byte(irq_control_plane_one_r, lane);
                                rsp_bytes_r[39:32] <= lane_byte(irq_control_plane_zero_r, lane);
                                rsp_count_r        <= 3'h5;
                            end
                        endcase
                    end
                    tx_load_r <= 1'b1;
                    state_r   <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (!tx_load_r && !tx_busy)
                        state_r <= ST_RECV;
                end
                default: state_r <= ST_RECV;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            port_is_input_r <= 32'h0;
        end else begin
            for (j = 0; j < 32; j = j + 1)
                port_is_input_r[j] <= ({drive_plane_two_r[j], drive_plane_one_r[j],
                                        drive_plane_zero_r[j]} == `UPC_DM_INPUT);
        end
    end

    // Response streamer on the reply endpoint.
    upc_resp_tx u_tx (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .load     (tx_load_r),
        .bytes_in (rsp_bytes_r),
        .count_in (rsp_count_r),
        .tdata_r  (ep1_tdata),
        .tvalid_r (ep1_tvalid),
        .tlast_r  (ep1_tlast),
        .tready   (ep1_tready),
        .busy_r   (tx_busy)
    );
endmodule // upc_cmd_handler

// File: verif/upc_cmd_handler_properties.sv
`timescale 1ns/1ps
// Endpoint handshake and port register checks, seen from the handler's own ports.
module upc_cmd_handler_chk (
    input wire        sys_clk,
    input wire        rst,
    input wire [7:0]  ep2_tdata,
    input wire        ep2_tvalid,
    input wire        ep2_tlast,
    input wire        ep2_tready_r,
    input wire [7:0]  ep1_tdata,
    input wire        ep1_tvalid,
    input wire        ep1_tlast,
    input wire        ep1_tready,
    input wire [31:0] drive_plane_two_r,
    input wire [31:0] drive_plane_one_r,
    input wire [31:0] drive_plane_zero_r,
    input wire [31:0] port_irq_enable_r,
    input wire [31:0] port_is_input_r
);
    reg  [7:0] op_r;
    reg  [7:0] sum_r;
    reg  [2:0] idx_r;
    reg        in_pkt_r;
    wire       cmd_take = ep2_tvalid && ep2_tready_r;
    wire       rsp_take = ep1_tvalid && ep1_tready;
    // Keeps the opcode and a running sum, so a reply is judged without a full model.
    always @(posedge sys_clk) begin
        if (rst) begin
            op_r     <= 8'h00;
            sum_r    <= 8'h00;
            idx_r    <= 3'h0;
            in_pkt_r <= 1'b0;
        end else begin
            if (cmd_take) in_pkt_r <= !ep2_tlast;
            if (cmd_take && !in_pkt_r) op_r <= ep2_tdata;
            if (rsp_take) idx_r <= ep1_tlast ? 3'h0 : idx_r + 3'h1;
            if (rsp_take) sum_r <= ep1_tlast ? 8'h00 : sum_r + ep1_tdata;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // A reply opens after exactly four quiet cycles that follow the closing command byte.
    sequence s_cmd_end; ep2_tvalid && ep2_tready_r && ep2_tlast; endsequence
    sequence s_rsp_open; !ep1_tvalid [*4] ##1 ep1_tvalid; endsequence
    property p_rsp_latency; s_cmd_end |=> s_rsp_open; endproperty
    a_rsp_latency: assert property (p_rsp_latency) else $error("late reply");
    // Handshake, ordering, response code and checksum of every reply, plus reset values and the input flag map.
    property p_hold; ep1_tvalid && !ep1_tready |=> ep1_tvalid && $stable(ep1_tdata); endproperty
    a_hold: assert property (p_hold) else $error("reply byte dropped");
    property p_no_cmd; ep1_tvalid |-> !ep2_tready_r; endproperty
    a_no_cmd: assert property (p_no_cmd) else $error("command taken during reply");
    property p_code; rsp_take && idx_r == 3'h0 |-> ep1_tdata == op_r + 8'h01; endproperty
    a_code: assert property (p_code) else $error("bad response code");
    property p_checksum; rsp_take && ep1_tlast |-> ep1_tdata == sum_r; endproperty
    a_checksum: assert property (p_checksum) else $error("bad checksum");
    property p_rst_vals; $fell(rst) |-> drive_plane_two_r == 32'hFFFFFFFF
        && drive_plane_zero_r == 32'hFFFFFFFF && port_irq_enable_r == 32'h00000000; endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset values");
    property p_input_map; !$past(rst) |-> port_is_input_r == (~$past(drive_plane_two_r)
        & $past(drive_plane_one_r) & ~$past(drive_plane_zero_r)); endproperty
    a_input_map: assert property (p_input_map) else $error("input flag mismatch");
    property p_regs_quiet;
        ep1_tvalid |-> $stable(drive_plane_two_r) && $stable(port_irq_enable_r);
    endproperty
    a_regs_quiet: assert property (p_regs_quiet) else $error("register moved in reply");
endmodule // upc_cmd_handler_chk

bind upc_cmd_handler upc_cmd_handler_chk u_chk (.sys_clk(sys_clk), .rst(rst),
    .ep2_tdata(ep2_tdata), .ep2_tvalid(ep2_tvalid), .ep2_tlast(ep2_tlast),
    .ep2_tready_r(ep2_tready_r), .ep1_tdata(ep1_tdata), .ep1_tvalid(ep1_tvalid),
    .ep1_tlast(ep1_tlast), .ep1_tready(ep1_tready), .drive_plane_two_r(drive_plane_two_r),
    .drive_plane_one_r(drive_plane_one_r), .drive_plane_zero_r(drive_plane_zero_r),
    .port_irq_enable_r(port_irq_enable_r), .port_is_input_r(port_is_input_r));

// File: verif/upc_host_model.sv
`timescale 1ns/1ps
// Host side of the two bulk endpoints; slow makes it stall every other reply cycle.
module upc_host_model (
    input  wire       sys_clk,
    input  wire       slow,
    output reg  [7:0] ep2_tdata,
    output reg        ep2_tvalid,
    output reg        ep2_tlast,
    input  wire       ep2_tready_r,
    input  wire [7:0] ep1_tdata,
    input  wire       ep1_tvalid,
    input  wire       ep1_tlast,
    output reg        ep1_tready
);
    initial begin
        ep2_tdata  = 8'h00;
        ep2_tvalid = 1'b0;
        ep2_tlast  = 1'b0;
        ep1_tready = 1'b0;
    end
    task send(input [39:0] cmd, input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(negedge sys_clk);
                ep2_tdata  <= cmd[39 - 8 * i -: 8];
                ep2_tvalid <= 1'b1;
                ep2_tlast  <= (i == n - 1);
                // Ready only moves on the rising edge, so the falling edge shows what is taken.
                while (!ep2_tready_r) @(negedge sys_clk);
                @(posedge sys_clk);
            end
            // The released line shows the inverse, so a stale byte never passes for data.
            @(negedge sys_clk);
            ep2_tdata  <= ~ep2_tdata;
            ep2_tvalid <= 1'b0;
            ep2_tlast  <= 1'b0;
        end
    endtask
    task recv(output [63:0] r, output integer k);
        integer t;
        reg     done;
        reg     rdy;
        begin
            r = 64'h0000000000000000;
            k = 0;
            t = 0;
            done = 1'b0;
            while (!done && k < 8) begin
                @(negedge sys_clk);
                rdy = !(slow && t[0]);
                ep1_tready <= rdy;
                t = t + 1;
                // The reply byte is settled here and is taken at the coming rising edge.
                if (ep1_tvalid && rdy) begin
                    r[8 * k +: 8] = ep1_tdata;
                    k = k + 1;
                    done = ep1_tlast;
                end
                @(posedge sys_clk);
            end
            @(negedge sys_clk);
            ep1_tready <= 1'b0;
        end
    endtask
endmodule // upc_host_model

// File: verif/tb_upc_cmd_handler.sv
`timescale 1ns/1ps
// Table rows through the host model, then a mode sweep and a reset while a reply is still pending.
module tb_upc_cmd_handler;
    typedef struct packed {
        logic [39:0] cmd;
        logic [2:0]  n;
        logic [7:0]  err;
        logic [2:0]  dcnt;
        logic [23:0] data;
    } upc_row_t;
    localparam [7:0] VER = 8'h5A; // Arbitrary version value.
    reg         sys_clk;
    reg         rst;
    reg         slow;
    wire [7:0]  ep2_tdata;
    wire [7:0]  ep1_tdata;
    wire        ep2_tvalid, ep2_tlast, ep2_tready_r, ep1_tvalid, ep1_tlast, ep1_tready;
    wire [31:0] drive_plane_two_r, drive_plane_one_r, drive_plane_zero_r, port_irq_enable_r;
    wire [31:0] port_global_select_r, irq_control_plane_one_r;
    wire [31:0] irq_control_plane_zero_r, port_is_input_r;
    integer     err_total, checked, cyc, i;
    upc_row_t   rows [0:15];
    upc_cmd_handler #(.FW_VERSION(VER)) DUT (
        .sys_clk(sys_clk), .rst(rst), .ep2_tdata(ep2_tdata), .ep2_tvalid(ep2_tvalid),
        .ep2_tlast(ep2_tlast), .ep2_tready_r(ep2_tready_r), .ep1_tdata(ep1_tdata),
        .ep1_tvalid(ep1_tvalid), .ep1_tlast(ep1_tlast), .ep1_tready(ep1_tready),
        .drive_plane_two_r(drive_plane_two_r), .drive_plane_one_r(drive_plane_one_r),
        .drive_plane_zero_r(drive_plane_zero_r), .port_irq_enable_r(port_irq_enable_r),
        .port_global_select_r(port_global_select_r),
        .irq_control_plane_one_r(irq_control_plane_one_r),
        .irq_control_plane_zero_r(irq_control_plane_zero_r), .port_is_input_r(port_is_input_r));
    upc_host_model host (
        .sys_clk(sys_clk), .slow(slow), .ep2_tdata(ep2_tdata), .ep2_tvalid(ep2_tvalid),
        .ep2_tlast(ep2_tlast), .ep2_tready_r(ep2_tready_r), .ep1_tdata(ep1_tdata),
        .ep1_tvalid(ep1_tvalid), .ep1_tlast(ep1_tlast),
        .ep1_tready(ep1_tready));
    task cmp(input [95:0] name, input [31:0] e, input [31:0] s);
        begin
            checked = checked + 1;
            if (s !== e) begin
                err_total = err_total + 1;
                $display("wrong value %0s expected %h seen %h", name, e, s);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", checked, err_total);
            if (err_total == 0 && checked > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    // Expected reply is rebuilt from the row: code, length, error, data, sum.
    task run(input upc_row_t w);
        reg [63:0] r;
        integer    k;
        integer    b;
        reg [7:0]  e;
        reg [7:0]  s;
        begin
            host.send(w.cmd, w.n);
            host.recv(r, k);
            s = 8'h00;
            for (b = 0; b < 3 + w.dcnt; b = b + 1) begin
                e = (b == 0) ? w.cmd[39:32] + 8'h01 : (b == 1) ? 8'h04 + w.dcnt
                    : (b == 2) ? w.err : w.data[23 - 8 * (b - 3) -: 8];
                s = s + e;
                cmp("reply byte", e, r[8 * b +: 8]);
            end
            cmp("checksum", s, r[8 * b +: 8]);
            cmp("reply count", 4 + w.dcnt, k);
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            stop_test;
        end
    end
    initial begin
        rst = 1'b1;
        slow = 1'b0;
        err_total = 0;
        checked = 0;
        cyc = 0;
        rows[0] = '{40'h0000000000, 3'd1, 8'h00, 3'd1, {VER, 16'h0000}};
        rows[1] = '{40'h2000000000, 3'd2, 8'h00, 3'd3, 24'hFFFFFF};
        rows[2] = '{40'h2202A53C0F, 3'd5, 8'h00, 3'd3, 24'hA53C0F};
        rows[3] = '{40'h2002000000, 3'd2, 8'h00, 3'd3, 24'hA53C0F};
        rows[4] = '{40'h32035E0000, 3'd3, 8'h00, 3'd1, 24'h5E0000};
        rows[5] = '{40'h3003000000, 3'd2, 8'h00, 3'd1, 24'h5E0000};
        rows[6] = '{40'h3604C30000, 3'd3, 8'h00, 3'd1, 24'hC30000};
        rows[7] = '{40'h3404000000, 3'd2, 8'h00, 3'd1, 24'hC30000};
        rows[8] = '{40'h3A00817E00, 3'd4, 8'h00, 3'd2, 24'h817E00};
        rows[9] = '{40'h3800000000, 3'd2, 8'h00, 3'd2, 24'h817E00};
        rows[10] = '{40'h4003020000, 3'd3, 8'h00, 3'd3, 24'h00FF00};
        rows[11] = '{40'h4004050000, 3'd3, 8'h00, 3'd3, 24'hFF00FF};
        rows[12] = '{40'h3201770000, 3'd3, 8'h02, 3'd0, 24'h000000};
        rows[13] = '{40'h4000080000, 3'd3, 8'h03, 3'd0, 24'h000000};
        rows[14] = '{40'h5000000000, 3'd1, 8'h01, 3'd0, 24'h000000};
        rows[15] = '{40'h2000000000, 3'd2, 8'h00, 3'd3, 24'hFFFFFF};
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        for (i = 0; i < 16; i = i + 1) run(rows[i]);
        cmp("plane two", 32'hFF00A5FF, drive_plane_two_r);
        cmp("plane zero", 32'hFF000FFF, drive_plane_zero_r);
        cmp("irq enable", 32'h005E0000, port_irq_enable_r);
        cmp("global sel", 32'hC3000000, port_global_select_r);
        cmp("irq ctl one", 32'h00000081, irq_control_plane_one_r);
        cmp("irq ctl zero", 32'h0000007E, irq_control_plane_zero_r);
        cmp("is input", 32'h00FF1000, port_is_input_r);
        // Every mode on one port, with the host stalling the reply.
        slow = 1'b1;
        for (i = 0; i < 8; i = i + 1) run(upc_row_t'{{8'h40, 8'h02, i[7:0], 16'h0000}, 3'd3,
            8'h00, 3'd3, {{8{i[2]}}, {8{i[1]}}, {8{i[0]}}}});
        // Reset while a reply is still pending must drop it and restore mode seven.
        host.send(40'h3200110000, 3);
        @(negedge sys_clk);
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        cmp("reply valid", 32'h00000000, ep1_tvalid);
        cmp("plane one", 32'hFFFFFFFF, drive_plane_one_r);
        cmp("irq enable", 32'h00000000, port_irq_enable_r);
        run(rows[1]);
        stop_test;
    end
endmodule // tb_upc_cmd_handler
